// ===== hw/mpcd_check.v
// mode page checker: validates compression and device configuration pages on
// mode select, returns them on mode sense, and runs the gap/fill write control
// assumes page bytes arrive as a valid/ready stream after a start pulse, and that
// the vendor page path delivers its gap threshold on a separate strobe
`include "mpcd_consts.vh"

// Overview of operation
// (R1) compression page only with page format flag
// (R2) compression page code must be 0Fh
// (R3) compression page length must be 0Eh
// (R4) host writes compress enable as zero
// (R5) sense returns compress capable as zero
// (R6) host writes decompress enable as zero
// (R7) host writes exception report field as 00
// (R8) both algorithm fields must be zero
// (R9) config page page format only, code 10h
// (R10) config page length must be 0Dh
// (R11) host writes partition change as zero
// (R12) format applied only when format-change set
// (R13) at most threshold gap blocks, then resume/stop
// (R14) pad track, then one or two gap tracks
// (R15) accept gap to FFh, clamp above 07h
// (R16) gap threshold defaults to 07h
// (R17) one shared gap threshold, last wins
// (R18) host writes partition byte as zero
// (R19) flush to tape once fill threshold reached
// (R20) fill default 80h, range 20h to D0h
// (R21) read empty ratio must equal fill ratio
// (R22) bad zero field or header rejects page
// (R23) reserved bits read back as zero
module mpcd_check #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4,
  parameter LVL_W      = 24
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             sel_start,
  input  wire             page_format_flag,
  input  wire [7:0]       sel_data,
  input  wire             sel_valid,
  output wire             sel_ready,
  output reg              sel_done_ff,
  output reg              sel_check_ff,
  output reg  [3:0]       sense_key_ff,
  input  wire             vendor_gap_valid,
  input  wire [7:0]       vendor_gap,
  input  wire             sense_start,
  input  wire             sense_page,
  input  wire             sense_ready,
  output reg  [7:0]       sense_data_ff,
  output reg              sense_valid_ff,
  output reg              sense_last_ff,
  output reg  [4:0]       active_format_ff,
  output reg  [2:0]       gap_threshold_ff,
  output reg  [7:0]       fill_threshold_ff,
  input  wire             write_active,
  input  wire [LVL_W-1:0] buffer_level,
  input  wire             gap_block_done,
  input  wire             track_end,
  input  wire             gap_track_done,
  output reg              flush_ff,
  output reg              gap_write_ff,
  output reg              gap_track_ff,
  output reg              tape_stop_ff
);
  localparam S_IDLE  = 2'h0;
  localparam S_RECV  = 2'h1;
  localparam S_DONE  = 2'h2;
  localparam G_RUN   = 3'h0;
  localparam G_GAP   = 3'h1;
  localparam G_PAD   = 3'h2;
  localparam G_TRK   = 3'h3;
  localparam G_STOP  = 3'h4;

  // ------------------------------------------------------------
  // byte fifo in front of the parser
  // ------------------------------------------------------------
  wire [7:0] fb_data;
  wire       fb_valid;
  reg  [1:0] st_ff;
  wire       fb_take;

  mpcd_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_data   (sel_data),
    .in_valid  (sel_valid),
    .in_ready  (sel_ready),
    .out_data  (fb_data),
    .out_valid (fb_valid),
    .out_ready (fb_take)
  );

  assign fb_take = fb_valid & (st_ff == S_RECV);

  // clamp of any gap value to the usable three-bit range
  function [2:0] gap_clamp;
    input [7:0] v;
    begin
      gap_clamp = (v > `MPCD_GAP_MAX) ? `MPCD_GAP_DFLT : v[2:0];
    end
  endfunction

  // ------------------------------------------------------------
  // mode select parser
  // ------------------------------------------------------------
  reg [4:0] idx_ff;
  reg       is_comp_ff;
  reg       bad_ff;
  reg       caf_ff;
  reg [4:0] fmt_ff;
  reg [7:0] fill_ff;
  reg       pf_ff;
  reg       nxt_bad;
  reg [4:0] last_idx;

  always @*
  begin
    nxt_bad  = 1'b0;
    last_idx = is_comp_ff ? (`MPCD_BYTES_COMP - 5'h01) : (`MPCD_BYTES_DEVCFG - 5'h01);
    case (idx_ff)
      5'h00:
      begin
        if (fb_data[5:0] == `MPCD_PAGE_COMP)
          nxt_bad = ~pf_ff; // R1
        else if (fb_data[5:0] == `MPCD_PAGE_DEVCFG)
          nxt_bad = ~pf_ff; // R9
        else
          nxt_bad = 1'b1; // R2 R22
        if (fb_data[7:6] != 2'h0)
          nxt_bad = 1'b1;
      end
      5'h01:
        nxt_bad = is_comp_ff ? (fb_data != `MPCD_LEN_COMP)  // R3
                             : (fb_data != `MPCD_LEN_DEVCFG); // R10
      5'h02:
        nxt_bad = is_comp_ff ? fb_data[7] : fb_data[6]; // R4 R11 R22
      5'h03:
        nxt_bad = is_comp_ff ? (fb_data[7:5] != 3'h0) : (fb_data != 8'h00); // R6 R7 R18
      5'h04:
        nxt_bad = is_comp_ff ? (fb_data != 8'h00)
                             : ((fb_data < `MPCD_FILL_MIN) | (fb_data > `MPCD_FILL_MAX)); // R8 R20
      5'h05:
        nxt_bad = is_comp_ff ? (fb_data != 8'h00) : (fb_data != fill_ff); // R8 R21
      5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b:
        nxt_bad = is_comp_ff & (fb_data != 8'h00); // R8
      default:
        nxt_bad = 1'b0;
    endcase
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_ff             <= S_IDLE;
      idx_ff            <= 5'h00;
      is_comp_ff        <= 1'b0;
      bad_ff            <= 1'b0;
      caf_ff            <= 1'b0;
      fmt_ff            <= 5'h00;
      fill_ff           <= 8'h00;
      pf_ff             <= 1'b0;
      sel_done_ff       <= 1'b0;
      sel_check_ff      <= 1'b0;
      sense_key_ff      <= `MPCD_SENSE_NONE;
      active_format_ff  <= {2'h0, `MPCD_GAP_DFLT};
      gap_threshold_ff  <= `MPCD_GAP_DFLT; // R16
      fill_threshold_ff <= `MPCD_FILL_DFLT; // R20
    end
    else
    begin
      sel_done_ff <= 1'b0;
      // vendor path shares the threshold; latest arrival wins
      if (vendor_gap_valid)
      begin
        gap_threshold_ff <= gap_clamp(vendor_gap); // R17 R15
      end
      case (st_ff)
        S_IDLE:
        begin
          if (sel_start)
          begin
            st_ff  <= S_RECV;
            idx_ff <= 5'h00;
            bad_ff <= 1'b0;
            pf_ff  <= page_format_flag;
          end
        end
        S_RECV:
        begin
          if (fb_take)
          begin
            if (idx_ff == 5'h00)
            begin
              is_comp_ff <= (fb_data[5:0] == `MPCD_PAGE_COMP);
            end
            if (idx_ff == 5'h02)
            begin
              caf_ff <= fb_data[5];
              fmt_ff <= fb_data[4:0];
            end
            if (idx_ff == 5'h04)
            begin
              fill_ff <= fb_data;
            end
            bad_ff <= bad_ff | nxt_bad; // R22
            idx_ff <= idx_ff + 5'h01;
            if ((idx_ff != 5'h00) && (idx_ff == last_idx))
            begin
              st_ff <= S_DONE;
            end
          end
        end
        S_DONE:
        begin
          st_ff        <= S_IDLE;
          sel_done_ff  <= 1'b1;
          sel_check_ff <= bad_ff;
          sense_key_ff <= bad_ff ? `MPCD_SENSE_ILLEGAL : `MPCD_SENSE_NONE; // R21 R22
          if (!bad_ff && !is_comp_ff)
          begin
            fill_threshold_ff <= fill_ff;
            if (caf_ff)
            begin
              active_format_ff <= {2'h0, fmt_ff[2:0]}; // R12
              gap_threshold_ff <= gap_clamp({5'h00, fmt_ff[2:0]}); // R12 R17
            end
          end
        end
        default:
          st_ff <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // mode sense reply
  // ------------------------------------------------------------
  reg [4:0] sidx_ff;
  reg       spage_ff;
  reg       sbusy_ff;
  reg [7:0] sbyte;
  reg [4:0] slast;

  always @*
  begin
    sbyte = 8'h00; // R23
    slast = spage_ff ? (`MPCD_BYTES_DEVCFG - 5'h01) : (`MPCD_BYTES_COMP - 5'h01);
    case (sidx_ff)
      5'h00: sbyte = {2'h0, spage_ff ? `MPCD_PAGE_DEVCFG : `MPCD_PAGE_COMP};
      5'h01: sbyte = spage_ff ? `MPCD_LEN_DEVCFG : `MPCD_LEN_COMP;
      5'h02: sbyte = spage_ff ? {3'h0, active_format_ff} : 8'h00; // R5
      5'h04: sbyte = spage_ff ? fill_threshold_ff : 8'h00;
      5'h05: sbyte = spage_ff ? fill_threshold_ff : 8'h00;
      5'h08: sbyte = spage_ff ? `MPCD_BIS_BIT : 8'h00;
      5'h0a: sbyte = spage_ff ? `MPCD_EEG_SEW : 8'h00;
      default: sbyte = 8'h00; // R23
    endcase
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sidx_ff        <= 5'h00;
      spage_ff       <= 1'b0;
      sbusy_ff       <= 1'b0;
      sense_data_ff  <= 8'h00;
      sense_valid_ff <= 1'b0;
      sense_last_ff  <= 1'b0;
    end
    else if (!sbusy_ff)
    begin
      if (sense_start)
      begin
        sbusy_ff <= 1'b1;
        spage_ff <= sense_page;
        sidx_ff  <= 5'h00;
      end
    end
    else if (!sense_valid_ff || sense_ready)
    begin
      if (sense_valid_ff && sense_last_ff)
      begin
        sbusy_ff       <= 1'b0;
        sense_valid_ff <= 1'b0;
        sense_last_ff  <= 1'b0;
      end
      else
      begin
        sense_data_ff  <= sbyte;
        sense_valid_ff <= 1'b1;
        sense_last_ff  <= (sidx_ff == slast);
        sidx_ff        <= sidx_ff + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // write-side gap and flush control
  // ------------------------------------------------------------
  reg  [2:0] gst_ff;
  reg  [2:0] gcnt_ff;
  reg        gtrk_ff;
  wire       buf_empty;
  wire       fill_hit;

  assign buf_empty = (buffer_level == {LVL_W{1'b0}});
  // level counts bytes; threshold counts 4-KByte units
  assign fill_hit  = ((buffer_level >> `MPCD_UNIT_SHIFT) >= {{(LVL_W-8){1'b0}}, fill_threshold_ff});

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gst_ff       <= G_RUN;
      gcnt_ff      <= 3'h0;
      gtrk_ff      <= 1'b0;
      flush_ff     <= 1'b0;
      gap_write_ff <= 1'b0;
      gap_track_ff <= 1'b0;
      tape_stop_ff <= 1'b0;
    end
    else
    begin
      case (gst_ff)
        G_RUN:
        begin
          tape_stop_ff <= 1'b0;
          flush_ff     <= write_active & fill_hit; // R19
          if (write_active && flush_ff && buf_empty)
          begin
            gst_ff       <= (gap_threshold_ff == 3'h0) ? G_PAD : G_GAP; // R13
            gcnt_ff      <= 3'h0;
            gap_write_ff <= 1'b1;
          end
        end
        G_GAP:
        begin
          if (!buf_empty)
          begin
            gst_ff       <= G_RUN;
            gap_write_ff <= 1'b0;
          end
          else if (gap_block_done)
          begin
            if (({1'b0, gcnt_ff} + 4'h1) >= {1'b0, gap_threshold_ff})
            begin
              gst_ff <= G_PAD; // R13
            end
            else
            begin
              gcnt_ff <= gcnt_ff + 3'h1; // R13
            end
          end
        end
        G_PAD:
        begin
          if (track_end)
          begin
            gst_ff       <= G_TRK; // R14
            gap_write_ff <= 1'b0;
            gap_track_ff <= 1'b1;
            gtrk_ff      <= 1'b0;
          end
        end
        G_TRK:
        begin
          // second gap track only if track boundary arrives with data still absent
          if (gap_track_done)
          begin
            if (gtrk_ff || !buf_empty)
            begin
              gst_ff       <= G_STOP; // R14
              gap_track_ff <= 1'b0;
            end
            else
            begin
              gtrk_ff <= 1'b1;
            end
          end
        end
        G_STOP:
        begin
          tape_stop_ff <= 1'b1;
          flush_ff     <= 1'b0;
          if (!write_active || fill_hit)
          begin
            gst_ff <= G_RUN;
          end
        end
        default:
          gst_ff <= G_RUN;
      endcase
    end
  end
endmodule

// ===== hw/mpcd_consts.vh
// constants for the mode page checker: page codes, lengths, field positions, defaults
// assumes inclusion by bare name from hw/ design files
`ifndef MPCD_CONSTS_VH
`define MPCD_CONSTS_VH
`define MPCD_PAGE_COMP      6'h0f
`define MPCD_LEN_COMP       8'h0e
`define MPCD_PAGE_DEVCFG    6'h10
`define MPCD_LEN_DEVCFG     8'h0d
`define MPCD_BYTES_COMP     5'h10
`define MPCD_BYTES_DEVCFG   5'h0f
`define MPCD_GAP_MAX        8'h07
`define MPCD_GAP_DFLT       3'h7
`define MPCD_FILL_DFLT      8'h80
`define MPCD_FILL_MIN       8'h20
`define MPCD_FILL_MAX       8'hd0
`define MPCD_SENSE_ILLEGAL  4'h5
`define MPCD_SENSE_NONE     4'h0
`define MPCD_UNIT_SHIFT     12
`define MPCD_BIS_BIT        8'h40
`define MPCD_EEG_SEW        8'h18
`endif

// ===== hw/mpcd_fifo.v
// synchronous fifo carrying page bytes from the initiator side into the checker
// assumes one clock and asynchronous active-high reset
module mpcd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop)
      begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end
      else if (pop & ~push)
      begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ===== testbench/mpcd_check_monitor.sv
// concurrent checks on the mode page checker top ports
// assumes one clock domain, asynchronous active-high reset
module mpcd_check_monitor #(
  parameter LVL_W = 24
) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             sel_done_ff,
  input wire logic             sel_check_ff,
  input wire logic [3:0]       sense_key_ff,
  input wire logic             vendor_gap_valid,
  input wire logic [7:0]       vendor_gap,
  input wire logic             sense_start,
  input wire logic             sense_ready,
  input wire logic [7:0]       sense_data_ff,
  input wire logic             sense_valid_ff,
  input wire logic [4:0]       active_format_ff,
  input wire logic [2:0]       gap_threshold_ff,
  input wire logic [7:0]       fill_threshold_ff,
  input wire logic             write_active,
  input wire logic [LVL_W-1:0] buffer_level,
  input wire logic             flush_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_reply;
    ##2 sense_valid_ff;
  endsequence
  sequence s_keep_fill;
    $stable(fill_threshold_ff) ##1 $stable(fill_threshold_ff);
  endsequence
  a_done_one_cycle: assert property (sel_done_ff |=> !sel_done_ff)
    else $error("page done pulse longer than one cycle");
  a_key_follows_check: assert property (sel_done_ff |-> sense_key_ff == (sel_check_ff ? 4'h5 : 4'h0))
    else $error("sense key does not match reject flag");
  a_vendor_gap_clamp: assert property (vendor_gap_valid |-> ##[1:2]
    gap_threshold_ff == ((vendor_gap > 8'h07) ? 3'h7 : vendor_gap[2:0]))
    else $error("vendor gap threshold not clamped or applied");
  a_flush_on_fill: assert property (##1 flush_ff ==
    $past(write_active && ((buffer_level >> 12) >= fill_threshold_ff)))
    else $error("flush does not follow fill threshold");
  a_sense_latency: assert property (sense_start && !sense_valid_ff |-> s_reply)
    else $error("sense reply late");
  a_sense_byte_hold: assert property (sense_valid_ff && !sense_ready |=> sense_valid_ff && $stable(sense_data_ff))
    else $error("sense byte dropped while stalled");
  a_format_at_done: assert property (!$stable(active_format_ff) |-> sel_done_ff || $past(sel_done_ff))
    else $error("active format changed outside page completion");
  a_reject_keeps_fill: assert property (sel_done_ff && sel_check_ff |-> s_keep_fill)
    else $error("rejected page changed fill threshold");
endmodule

bind mpcd_check mpcd_check_monitor #(.LVL_W(LVL_W)) u_mpcd_check_monitor (
  .clk(clk), .reset(reset), .sel_done_ff(sel_done_ff), .sel_check_ff(sel_check_ff),
  .sense_key_ff(sense_key_ff), .vendor_gap_valid(vendor_gap_valid), .vendor_gap(vendor_gap),
  .sense_start(sense_start), .sense_ready(sense_ready), .sense_data_ff(sense_data_ff),
  .sense_valid_ff(sense_valid_ff), .active_format_ff(active_format_ff), .gap_threshold_ff(gap_threshold_ff),
  .fill_threshold_ff(fill_threshold_ff), .write_active(write_active), .buffer_level(buffer_level),
  .flush_ff(flush_ff));

// ===== testbench/mpcd_init_model.sv
// initiator model: streams mode select page bytes over valid/ready
// assumes the bench pulses the start strobe before calling send
module mpcd_init_model (
  input wire logic  clk,
  output logic [7:0] sel_data,
  output logic       sel_valid,
  input wire logic  sel_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sel_data = 8'h00;
    sel_valid = 1'b0;
  end
  // ----------------------------------------
  // byte stream, first byte in top bits
  // ----------------------------------------
  task automatic send(input logic [127:0] pg, input int n);
    for (int i = 0; i < n; i++)
    begin
      sel_data = pg[127-8*i -: 8];
      sel_valid = 1'b1;
      while (sel_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
    end
    sel_valid = 1'b0;
    // released line shows the inverse, not a stale byte
    sel_data = ~sel_data;
  endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the mode page checker
// assumes 125 MHz clock, inputs driven 1 ns after the rising edge
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset, sel_start, page_format_flag, sel_valid, sel_ready, sel_done_ff, sel_check_ff;
  logic [7:0]  sel_data, vendor_gap, sense_data_ff, fill_threshold_ff, got[40];
  logic [3:0]  sense_key_ff;
  logic        vendor_gap_valid, sense_start, sense_page, sense_ready, sense_valid_ff, sense_last_ff;
  logic [4:0]  active_format_ff;
  logic [2:0]  gap_threshold_ff;
  logic        write_active, gap_block_done, track_end, gap_track_done;
  logic [23:0] buffer_level;
  logic        flush_ff, gap_write_ff, gap_track_ff, tape_stop_ff;
  int          errors, checks_done, cycles;
  mpcd_check u_mpcd_check (.clk(clk), .reset(reset), .sel_start(sel_start), .page_format_flag(page_format_flag),
    .sel_data(sel_data), .sel_valid(sel_valid), .sel_ready(sel_ready), .sel_done_ff(sel_done_ff),
    .sel_check_ff(sel_check_ff), .sense_key_ff(sense_key_ff), .vendor_gap_valid(vendor_gap_valid),
    .vendor_gap(vendor_gap), .sense_start(sense_start), .sense_page(sense_page), .sense_ready(sense_ready),
    .sense_data_ff(sense_data_ff), .sense_valid_ff(sense_valid_ff), .sense_last_ff(sense_last_ff),
    .active_format_ff(active_format_ff), .gap_threshold_ff(gap_threshold_ff),
    .fill_threshold_ff(fill_threshold_ff), .write_active(write_active), .buffer_level(buffer_level),
    .gap_block_done(gap_block_done), .track_end(track_end), .gap_track_done(gap_track_done),
    .flush_ff(flush_ff), .gap_write_ff(gap_write_ff), .gap_track_ff(gap_track_ff), .tape_stop_ff(tape_stop_ff));
  mpcd_init_model u_mpcd_init_model (.clk(clk), .sel_data(sel_data), .sel_valid(sel_valid), .sel_ready(sel_ready));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk) #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      give_verdict();
    end
  end
  task automatic sel(input logic pf, input logic [127:0] pg, input int n, input logic rej);
    page_format_flag = pf;
    sel_start = 1'b1;
    tick();
    sel_start = 1'b0;
    u_mpcd_init_model.send(pg, n);
    for (int i = 0; i < 20 && sel_done_ff !== 1'b1; i++) tick();
    chk(sel_done_ff, 1'b1);
    chk(sel_check_ff, rej);
    chk(sense_key_ff, rej ? 4'h5 : 4'h0);
    tick();
  endtask
  function automatic logic [127:0] cfg(input logic [7:0] b2, b3, b4, b5);
    return {8'h10, 8'h0d, b2, b3, b4, b5, 80'h0};
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults();
    chk(gap_threshold_ff, 3'h7);
    chk(fill_threshold_ff, 8'h80);
  endtask
  task automatic t_comp();
    int idx[7] = '{0, 1, 2, 3, 3, 4, 11};
    logic [7:0] val[7] = '{8'h01, 8'h01, 8'h80, 8'h80, 8'h20, 8'h01, 8'h01};
    logic [127:0] pg = {8'h0f, 8'h0e, 112'h0};
    sel(1'b1, pg, 16, 1'b0);
    sel(1'b0, pg, 16, 1'b1);
    // an unknown page code is parsed at config length
    for (int i = 0; i < 7; i++)
      sel(1'b1, pg ^ ({120'h0, val[i]} << (8 * (15 - idx[i]))), (idx[i] == 0) ? 15 : 16, 1'b1);
  endtask
  task automatic t_cfg();
    logic [7:0] b[5][4] = '{'{8'h00, 8'h00, 8'h1f, 8'h1f}, '{8'h00, 8'h00, 8'hd1, 8'hd1},
      '{8'h00, 8'h00, 8'h40, 8'h41}, '{8'h00, 8'h01, 8'h40, 8'h40}, '{8'h40, 8'h00, 8'h40, 8'h40}};
    sel(1'b1, cfg(8'h23, 8'h00, 8'h20, 8'h20), 15, 1'b0);
    chk(active_format_ff, 5'h03);
    chk(fill_threshold_ff, 8'h20);
    sel(1'b1, cfg(8'h05, 8'h00, 8'hd0, 8'hd0), 15, 1'b0);
    chk(active_format_ff, 5'h03);
    chk(fill_threshold_ff, 8'hd0);
    for (int i = 0; i < 5; i++)
      sel(1'b1, cfg(b[i][0], b[i][1], b[i][2], b[i][3]), 15, 1'b1);
    sel(1'b0, cfg(8'h00, 8'h00, 8'h20, 8'h20), 15, 1'b1);
    chk(fill_threshold_ff, 8'hd0);
  endtask
  task automatic t_vendor();
    vendor_gap = 8'hff;
    vendor_gap_valid = 1'b1;
    tick();
    vendor_gap_valid = 1'b0;
    tick(2);
    chk(gap_threshold_ff, 3'h7);
    sel(1'b1, cfg(8'h22, 8'h00, 8'h20, 8'h20), 15, 1'b0);
    chk(gap_threshold_ff, 3'h2);
  endtask
  task automatic t_sense(input logic pg, input int n);
    int k = 0;
    logic fin = 1'b0;
    sense_page = pg;
    sense_ready = 1'b0;
    sense_start = 1'b1;
    tick();
    sense_start = 1'b0;
    tick(4);
    sense_ready = 1'b1;
    for (int i = 0; i < 40 && !fin; i++)
    begin
      if (sense_valid_ff === 1'b1)
      begin
        got[k] = sense_data_ff;
        k++;
        fin = sense_last_ff;
      end
      tick();
    end
    sense_ready = 1'b0;
    chk(k, n);
    chk(got[0], pg ? 8'h10 : 8'h0f);
    chk(got[1], pg ? 8'h0d : 8'h0e);
    if (pg)
    begin
      chk(got[2], 8'h02);
      chk({got[4], got[5]}, 16'h2020);
      chk({got[8], got[10]}, 16'h4018);
    end
    else
      for (int i = 2; i < 16; i++) chk(got[i], 8'h00);
  endtask
  task automatic pulse(ref logic s, input int n);
    repeat (n)
    begin
      s = 1'b1;
      tick();
      s = 1'b0;
      tick();
    end
    tick(2);
  endtask
  task automatic t_write();
    write_active = 1'b1;
    buffer_level = 24'h01f000;
    tick(3);
    chk(flush_ff, 1'b0);
    buffer_level = 24'h020000;
    tick(3);
    chk(flush_ff, 1'b1);
    buffer_level = 24'h000000;
    tick(3);
    chk(gap_write_ff, 1'b1);
    pulse(gap_block_done, 1);
    pulse(track_end, 1);
    chk(gap_track_ff, 1'b0);
    pulse(gap_block_done, 1);
    pulse(track_end, 1);
    chk(gap_track_ff, 1'b1);
    pulse(gap_track_done, 1);
    chk(tape_stop_ff, 1'b0);
    pulse(gap_track_done, 1);
    chk(tape_stop_ff, 1'b1);
    write_active = 1'b0;
    tick(3);
    chk(tape_stop_ff, 1'b0);
    // data mid-gap resumes; data in the first gap track cuts to stop
    write_active = 1'b1;
    buffer_level = 24'h020000;
    tick(3);
    buffer_level = 24'h000000;
    tick(3);
    buffer_level = 24'h001000;
    tick(2);
    chk(gap_write_ff, 1'b0);
    buffer_level = 24'h020000;
    tick(3);
    buffer_level = 24'h000000;
    tick(3);
    pulse(gap_block_done, 2);
    pulse(track_end, 1);
    buffer_level = 24'h001000;
    pulse(gap_track_done, 1);
    chk(tape_stop_ff, 1'b1);
    write_active = 1'b0;
    tick(3);
    chk(tape_stop_ff, 1'b0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {errors, checks_done, cycles} = '0;
    {sel_start, page_format_flag, vendor_gap_valid, sense_start, sense_page, sense_ready} = '0;
    {write_active, gap_block_done, track_end, gap_track_done} = '0;
    vendor_gap = 8'h00;
    buffer_level = 24'h000000;
    reset = 1'b1;
    tick(6);
    reset = 1'b0;
    t_defaults();
    t_comp();
    t_cfg();
    t_vendor();
    t_sense(1'b0, 16);
    t_sense(1'b1, 15);
    t_write();
    give_verdict();
  end
endmodule
